// [ccot_pkg.sv]
// package: constants and types for the capture/compare output timing block
package ccot_pkg;
    localparam int TIMER_W         = 16;
    localparam int PORT_W          = 8;
    localparam int TOGGLE_LO       = 6;
    localparam int TOGGLE_HI       = 7;
    localparam int FLAG_W          = 4;
    localparam int FLAG_CAPTURE    = 0;
    localparam int FLAG_SET        = 1;
    localparam int FLAG_RESET      = 2;
    localparam int FLAG_TOGGLE     = 3;
    localparam logic [15:0] TIMER_RST   = 16'h0000;
    localparam logic [15:0] COMPARE_RST = 16'hFFFF;
    localparam logic [7:0]  PORT_RST    = 8'h00;
    localparam logic [7:0]  MASK_RST    = 8'h00;
    localparam logic [3:0]  FLAGS_RST   = 4'h0;
    localparam logic [2:0]  PRESC_RST   = 3'h0;
    // division select codes
    typedef enum logic [1:0] {
        CCOT_DIV1 = 2'h0,
        CCOT_DIV2 = 2'h1,
        CCOT_DIV4 = 2'h3,
        CCOT_DIV8 = 2'h2
    } ccot_div_t;
endpackage

// [ccot_match.sv]
// one compare unit: single-cycle match pulse on a new timer tick
module ccot_match #(
    parameter int W = 16
) (
    input  wire logic         MCLK,
    input  wire logic         RST,
    input  wire logic         CE,
    input  wire logic         TICK,
    input  wire logic [W-1:0] TIMER,
    input  wire logic [W-1:0] CMP,
    output logic              HIT
);
    logic hit_q;
    logic hit_d;

    always_comb begin
        hit_d = 1'b0;
        if (TICK && (TIMER == CMP)) begin
            hit_d = 1'b1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            hit_q <= 1'b0;
        end else if (CE) begin
            hit_q <= hit_d;
        end
    end

    assign HIT = hit_q & CE;
endmodule

// [ccot_top.sv]
// top: timer, prescaler, capture 0, three compare units, output port and flags
// Overview of operation
// - capture input rising edge copies timer into capture register zero, raises flag.
// - timer equal to set compare drives high the lower six port bits enabled in set mask.
// - timer equal to reset compare drives low the lower six port bits enabled in reset mask.
// - toggle compare match inverts enabled coil bits and sets toggle flag.
// - each port bit obeys only its own bits of the set mask and the reset/toggle mask.
// - flags sit in one flag register, stay set until software clears.
// - timer is 16-bit, compared against three 16-bit compare registers.
// - only port bits six and seven toggle; lower six use set/reset.
// - timer advances through prescaler dividing by 1, 2, 4 or 8.
module ccot_top #(
    parameter int TW = ccot_pkg::TIMER_W,
    parameter int PW = ccot_pkg::PORT_W
) (
    input  wire logic                          MCLK,
    input  wire logic                          RST,
    input  wire logic                          CE,
    input  wire logic                          TIMER_RUN,
    input  wire ccot_pkg::ccot_div_t           PRESCALE_SEL,
    input  wire logic                          CAPTURE_INPUT_ZERO,
    input  wire logic [TW-1:0]                 COMPARE_SET_REG,
    input  wire logic [TW-1:0]                 COMPARE_RESET_REG,
    input  wire logic [TW-1:0]                 COMPARE_TOGGLE_REG,
    input  wire logic [PW-1:0]                 SET_ENABLE_MASK,
    input  wire logic [PW-1:0]                 RESET_TOGGLE_ENABLE_MASK,
    input  wire logic                          FLAG_WR,
    input  wire logic [ccot_pkg::FLAG_W-1:0]   FLAG_CLR,
    output logic [TW-1:0]                      MAIN_CAPTURE_TIMER,
    output logic [TW-1:0]                      CAPTURE_REG_ZERO,
    output logic [PW-1:0]                      OUTPUT_PORT,
    output logic [ccot_pkg::FLAG_W-1:0]        TIMER_IRQ_FLAG_REG
);
    logic [2:0]                    presc_q;
    logic [2:0]                    presc_d;
    logic                          tick_d;
    logic [TW-1:0]                 timer_q;
    logic [TW-1:0]                 timer_d;
    logic                          cap_in_q;
    logic                          cap_in_d;
    logic [TW-1:0]                 cap_q;
    logic [TW-1:0]                 cap_d;
    logic [PW-1:0]                 port_q;
    logic [PW-1:0]                 port_d;
    logic [ccot_pkg::FLAG_W-1:0]   flags_q;
    logic [ccot_pkg::FLAG_W-1:0]   flags_d;
    logic [ccot_pkg::FLAG_W-1:0]   events;
    logic [ccot_pkg::FLAG_W-1:0]   clear_bits;
    logic                          cap_edge;
    logic                          hit_set;
    logic                          hit_reset;
    logic                          hit_toggle;
    logic [PW-1:0]                 coil_mask;
    logic [PW-1:0]                 toggle_bits;
    logic [PW-1:0]                 set_bits;
    logic [PW-1:0]                 reset_bits;

    // prescaler, cleared while the timer is stopped
    always_comb begin
        presc_d = presc_q + 3'h1;
        tick_d  = 1'b0;
        if (!TIMER_RUN) begin
            presc_d = ccot_pkg::PRESC_RST;
        end else begin
            unique case (PRESCALE_SEL)
                ccot_pkg::CCOT_DIV1: tick_d = 1'b1;
                ccot_pkg::CCOT_DIV2: tick_d = (presc_q[0] == 1'b1);
                ccot_pkg::CCOT_DIV4: tick_d = (presc_q[1:0] == 2'h3);
                ccot_pkg::CCOT_DIV8: tick_d = (presc_q == 3'h7);
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            presc_q <= ccot_pkg::PRESC_RST;
        end else if (CE) begin
            presc_q <= presc_d;
        end
    end

    // timer advances on each prescaler tick
    always_comb begin
        timer_d = timer_q;
        if (tick_d) begin
            timer_d = timer_q + {{(TW-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            timer_q <= TW'(ccot_pkg::TIMER_RST);
        end else if (CE) begin
            timer_q <= timer_d;
        end
    end

    // match units, one per compare register
    ccot_match #(.W(TW)) u_set (
        .MCLK  (MCLK),
        .RST   (RST),
        .CE    (CE),
        .TICK  (tick_d),
        .TIMER (timer_d),
        .CMP   (COMPARE_SET_REG),
        .HIT   (hit_set)
    );

    ccot_match #(.W(TW)) u_reset (
        .MCLK  (MCLK),
        .RST   (RST),
        .CE    (CE),
        .TICK  (tick_d),
        .TIMER (timer_d),
        .CMP   (COMPARE_RESET_REG),
        .HIT   (hit_reset)
    );

    ccot_match #(.W(TW)) u_toggle (
        .MCLK  (MCLK),
        .RST   (RST),
        .CE    (CE),
        .TICK  (tick_d),
        .TIMER (timer_d),
        .CMP   (COMPARE_TOGGLE_REG),
        .HIT   (hit_toggle)
    );

    // capture edge; the sampled pin follows the input through reset, so no false edge
    assign cap_edge = CAPTURE_INPUT_ZERO & ~cap_in_q;

    always_comb begin
        cap_in_d = CAPTURE_INPUT_ZERO;
        cap_d    = cap_q;
        if (cap_edge) begin
            cap_d = timer_q;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            cap_in_q <= CAPTURE_INPUT_ZERO;
            cap_q    <= TW'(ccot_pkg::TIMER_RST);
        end else if (CE) begin
            cap_in_q <= cap_in_d;
            cap_q    <= cap_d;
        end
    end

    // the two coil bits of the port
    always_comb begin
        coil_mask                      = '0;
        coil_mask[ccot_pkg::TOGGLE_LO] = 1'b1;
        coil_mask[ccot_pkg::TOGGLE_HI] = 1'b1;
    end

    always_comb begin
        toggle_bits = RESET_TOGGLE_ENABLE_MASK & coil_mask;
        set_bits    = SET_ENABLE_MASK & ~coil_mask;
        reset_bits  = RESET_TOGGLE_ENABLE_MASK & ~coil_mask;
    end

    // port updates in set, reset, toggle order
    always_comb begin
        port_d = port_q;
        if (hit_set) begin
            port_d = port_d | set_bits;
        end
        if (hit_reset) begin
            port_d = port_d & ~reset_bits;
        end
        if (hit_toggle) begin
            port_d = port_d ^ toggle_bits;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            port_q <= PW'(ccot_pkg::PORT_RST);
        end else if (CE) begin
            port_q <= port_d;
        end
    end

    // flag events and software clear
    always_comb begin
        events                         = '0;
        events[ccot_pkg::FLAG_CAPTURE] = cap_edge;
        events[ccot_pkg::FLAG_SET]     = hit_set;
        events[ccot_pkg::FLAG_RESET]   = hit_reset;
        events[ccot_pkg::FLAG_TOGGLE]  = hit_toggle;
        clear_bits                     = '0;
        if (FLAG_WR) begin
            clear_bits = FLAG_CLR;
        end
        flags_d = (flags_q & ~clear_bits) | events;
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            flags_q <= ccot_pkg::FLAGS_RST;
        end else if (CE) begin
            flags_q <= flags_d;
        end
    end

    // outputs come straight from the registers
    assign MAIN_CAPTURE_TIMER = timer_q;
    assign CAPTURE_REG_ZERO   = cap_q;
    assign OUTPUT_PORT        = port_q;
    assign TIMER_IRQ_FLAG_REG = flags_q;
endmodule

// [ccot_monitor.sv]
// checker: port-level properties of the capture/compare block
module ccot_monitor #(parameter int TW = 16, parameter int PW = 8) (
    input wire logic          MCLK,
    input wire logic          RST,
    input wire logic          CE,
    input wire logic          CAPTURE_INPUT_ZERO,
    input wire logic [TW-1:0] COMPARE_SET_REG,
    input wire logic [TW-1:0] COMPARE_RESET_REG,
    input wire logic [TW-1:0] COMPARE_TOGGLE_REG,
    input wire logic [PW-1:0] SET_ENABLE_MASK,
    input wire logic [PW-1:0] RESET_TOGGLE_ENABLE_MASK,
    input wire logic          FLAG_WR,
    input wire logic [3:0]    FLAG_CLR,
    input wire logic [TW-1:0] MAIN_CAPTURE_TIMER,
    input wire logic [TW-1:0] CAPTURE_REG_ZERO,
    input wire logic [PW-1:0] OUTPUT_PORT,
    input wire logic [3:0]    TIMER_IRQ_FLAG_REG
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic [TW-1:0] t = MAIN_CAPTURE_TIMER;
    wire logic [PW-1:0] p = OUTPUT_PORT;
    wire logic [3:0]    f = TIMER_IRQ_FLAG_REG;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST || !CE);
    capture_copy_a: assert property ($rose(CAPTURE_INPUT_ZERO) |=> CAPTURE_REG_ZERO == $past(t) && f[0])
        else $error("bad capture");
    set_match_a: assert property (
        $changed(t) && !$past(RST) && t == COMPARE_SET_REG && t != COMPARE_RESET_REG
        |=> (p & $past(SET_ENABLE_MASK) & 8'h3F) == ($past(SET_ENABLE_MASK) & 8'h3F) && f[1]) else $error("bad set");
    reset_match_a: assert property (
        $changed(t) && !$past(RST) && t == COMPARE_RESET_REG
        |=> (p & $past(RESET_TOGGLE_ENABLE_MASK) & 8'h3F) == 8'h00 && f[2]) else $error("bad reset");
    toggle_match_a: assert property (
        $changed(t) && !$past(RST) && t == COMPARE_TOGGLE_REG
        |=> p[7:6] == ($past(p) ^ $past(RESET_TOGGLE_ENABLE_MASK)) >> 6 && f[3]) else $error("bad toggle");
    low_bits_a: assert property (
        $changed(t) && !$past(RST) && t == COMPARE_TOGGLE_REG && t != COMPARE_SET_REG && t != COMPARE_RESET_REG
        |=> $stable(p[5:0])) else $error("low bits moved");
    flag_hold_a: assert property (f[2] && !(FLAG_WR && FLAG_CLR[2]) |=> f[2])
        else $error("flag lost");
    timer_step_a: assert property ($changed(t) && !$past(RST) |-> t == $past(t) + 16'h0001)
        else $error("bad timer step");
    port_quiet_a: assert property ($stable(t) |=> $stable(p))
        else $error("port moved");
    cover property ($rose(CAPTURE_INPUT_ZERO));
    cover property (FLAG_WR);
    cover property ($rose(p[7]));
endmodule
bind ccot_top ccot_monitor #(.TW(TW), .PW(PW)) i_mon (.*);

// [ccot_coil_model.sv]
// partner: coil driver stages counting switch events
module ccot_coil_model (
    input  wire logic       mclk,
    input  wire logic [1:0] coil,
    output int              switches
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] last_q = 2'h0;
    initial switches = 0;
    always @(posedge mclk) begin
        switches <= switches + $countones(coil ^ last_q);
        last_q <= coil;
    end
endmodule

// [ccot_top_tb_top.sv]
// testbench: compare, capture, prescaler and reload sequences
module ccot_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                mclk = 1'b0, rst = 1'b1, run = 1'b1, cap = 1'b0, fwr = 1'b0, ce = 1'b1;
    logic [3:0]          fclr = 4'h0, flags;
    logic [7:0]          rm = 8'h41, port;
    logic [15:0]         ct = 16'h0030, tmr, capv;
    ccot_pkg::ccot_div_t sel = ccot_pkg::CCOT_DIV1;
    int                  miscompares = 0, n_tests = 0, sw;
    initial forever #20 mclk = ~mclk;
    ccot_top i_dut (.MCLK(mclk), .RST(rst), .CE(ce), .TIMER_RUN(run), .PRESCALE_SEL(sel),
        .CAPTURE_INPUT_ZERO(cap), .COMPARE_SET_REG(16'h0010), .COMPARE_RESET_REG(16'h0020),
        .COMPARE_TOGGLE_REG(ct), .SET_ENABLE_MASK(8'hC5), .RESET_TOGGLE_ENABLE_MASK(rm),
        .FLAG_WR(fwr), .FLAG_CLR(fclr), .MAIN_CAPTURE_TIMER(tmr), .CAPTURE_REG_ZERO(capv),
        .OUTPUT_PORT(port), .TIMER_IRQ_FLAG_REG(flags));
    ccot_coil_model i_coil (.mclk(mclk), .coil(port[7:6]), .switches(sw));
    task automatic chk(logic [15:0] got, logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_flag(int b);
        int i;
        for (i = 0; i < 300 && flags[b] !== 1'b1; i++)
            @(posedge mclk) #1;
        if (i == 300) begin
            miscompares++;
            report_and_stop();
        end
    endtask
    task automatic clr(logic [3:0] m);
        @(posedge mclk);
        fwr <= 1'b1;
        fclr <= m;
        @(posedge mclk);
        fwr <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        wait_flag(1);
        chk(port, 8'h05);
        chk(flags, 4'h2);
        clr(4'h2);
        chk(flags, 4'h0);
        wait_flag(2);
        chk(port, 8'h04);
        wait_flag(3);
        chk(port, 8'h44);
        chk(flags, 4'hC);
        $display("done: compare");
        @(posedge mclk);
        cap <= 1'b1;
        run <= 1'b0;
        ct <= 16'h0040;
        rm <= 8'h81;
        @(posedge mclk) #1;
        chk(capv, 16'h0032);
        chk(flags, 4'hD);
        $display("done: capture");
        @(posedge mclk);
        run <= 1'b1;
        cap <= 1'b0;
        sel <= ccot_pkg::CCOT_DIV8;
        repeat (40) @(posedge mclk);
        run <= 1'b0;
        #1 chk(tmr, 16'h0037);
        @(posedge mclk);
        run <= 1'b1;
        sel <= ccot_pkg::CCOT_DIV2;
        repeat (8) @(posedge mclk);
        run <= 1'b0;
        #1 chk(tmr, 16'h003B);
        @(posedge mclk);
        run <= 1'b1;
        sel <= ccot_pkg::CCOT_DIV4;
        repeat (8) @(posedge mclk);
        run <= 1'b0;
        #1 chk(tmr, 16'h003D);
        $display("done: prescale");
        clr(4'hF);
        @(posedge mclk);
        sel <= ccot_pkg::CCOT_DIV1;
        run <= 1'b1;
        wait_flag(3);
        chk(port, 8'hC4);
        @(posedge mclk) #1;
        chk(16'(sw), 16'h0002);
        $display("done: reload");
        @(posedge mclk);
        ce <= 1'b0;
        repeat (5) @(posedge mclk);
        #1 chk(tmr, 16'h0043);
        @(posedge mclk);
        ce <= 1'b1;
        @(posedge mclk) #1;
        chk(tmr, 16'h0044);
        $display("done: clock enable");
        report_and_stop();
    end
endmodule
